// [logic/pmt8_defines.svh]
// Purpose: named constants of the eight-bit period match timer
// Assumes: 32-bit classic Wishbone register bus, word addressed by adr[4:2]
// Notes:   definitions only
`ifndef PMT8_DEFINES_SVH
`define PMT8_DEFINES_SVH

// ==========================================================
// register word indices
`define PMT8_IDX_COUNT     3'h0
`define PMT8_IDX_PERIOD    3'h1
`define PMT8_IDX_CONTROL   3'h2
`define PMT8_IDX_FLAG      3'h3
`define PMT8_IDX_ENABLE    3'h4
`define PMT8_ADR_MSB       4
`define PMT8_ADR_LSB       2

// ==========================================================
// control field layout
`define PMT8_PS_MSB        1
`define PMT8_PS_LSB        0
`define PMT8_RUN_BIT       2
`define PMT8_POST_MSB      6
`define PMT8_POST_LSB      3
`define PMT8_IRQ_BIT       1

// ==========================================================
// codes, terminal counts, reset values
`define PMT8_PS_DIV1       2'h0
`define PMT8_PS_DIV4       2'h1
`define PMT8_PRE_TC1       4'h0
`define PMT8_PRE_TC4       4'h3
`define PMT8_PRE_TC16      4'hF
`define PMT8_QTR_TC        2'h3
`define PMT8_COUNT_RST     8'h00
`define PMT8_PERIOD_RST    8'hFF
`define PMT8_CTL_RST       7'h00
`define PMT8_DATA_ZERO     32'h0000_0000
`define PMT8_HI_ZERO       24'h00_0000
`define PMT8_FLAG_HI_ZERO  30'h0000_0000
`define PMT8_BIT0_ZERO     1'h0

`endif

// [logic/pmt8_pkg.sv]
// Purpose: types of the eight-bit period match timer
// Assumes: pmt8_defines.svh holds the numbers
// Notes:   one packed struct carries all state except the reset synchronizer
package pmt8_pkg;

	typedef struct packed {
		logic [1:0]  qtr;
		logic [3:0]  pre;
		logic [3:0]  post;
		logic [7:0]  cnt;
		logic [7:0]  per;
		logic [6:0]  ctl;
		logic        flag;
		logic        ien;
		logic        ack;
		logic [31:0] dat;
		logic        match;
		logic        shclk;
	} pmt8_state_t;

endpackage : pmt8_pkg

// [logic/pmt8_top.sv]
// Purpose: eight-bit period match timer with pre/postscaler and match interrupt
// Assumes: mclk 25 MHz, classic Wishbone slave, rst_n asynchronous active low
// Notes:   instruction clock is mclk divided by four
//
// Functional notes
// - When running the count advances by one from zero on each prescaled instruction clock tick (mclk/4).
// - A four-bit prescale counter divides ticks by 1, 4 or 16 for prescale codes 00, 01 and 1x.
// - The count is compared with the period value at each increment and an equal value yields the match signal.
// - A match returns the count to zero at the next increment and advances the postscale counter.
// - The postscale field selects 1:1 through 1:16 as code plus one matches per flag.
// - The postscaler sets the latched flag in bit 1 of the flag register, and bit 1 of the enable register gates the interrupt.
// - Reset clears the count and sets the period value to all ones.
// - Writes to the count or the control register, and any reset, clear both scaler counters.
// - A control write leaves the count unchanged.
// - Control bit 2 switches the timer on and off.
// - Count and period value are readable and writable eight-bit registers.
// - Control bit 7 is unimplemented and reads as zero.
// - The unscaled match pulse is exported as a time base, and a register that toggles on each match is exported as a serial shift clock.
`timescale 1ns/1ps
`default_nettype none
`include "pmt8_defines.svh"

module pmt8_top (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq,
	output logic             match_pulse,
	output logic             shift_clk
);
	import pmt8_pkg::*;

	// ==========================================================
	// reset release
	logic [1:0] rst_sync_r;
	logic       rst_l;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	assign rst_l = rst_sync_r[1];

	// ==========================================================
	// state
	localparam pmt8_state_t ST_RST = '{
		qtr:   2'h0,
		pre:   4'h0,
		post:  4'h0,
		cnt:   `PMT8_COUNT_RST,
		per:   `PMT8_PERIOD_RST,
		ctl:   `PMT8_CTL_RST,
		flag:  1'b0,
		ien:   1'b0,
		ack:   1'b0,
		dat:   `PMT8_DATA_ZERO,
		match: 1'b0,
		shclk: 1'b0
	};

	pmt8_state_t s_r;
	pmt8_state_t s_nxt;

	logic       acc;
	logic       wr;
	logic       tick;
	logic       inc;
	logic       set_flag;
	logic       clr_flag;
	logic       run;
	logic [3:0] pre_tc;
	logic [2:0] idx;
	logic [7:0] wbyte;

	// ==========================================================
	// next state
	always_comb begin
		s_nxt    = s_r;
		acc      = wb_cyc_i & wb_stb_i & ~s_r.ack;
		wr       = acc & wb_we_i & wb_sel_i[0];
		idx      = wb_adr_i[`PMT8_ADR_MSB:`PMT8_ADR_LSB];
		wbyte    = wb_dat_i[7:0];
		run      = s_r.ctl[`PMT8_RUN_BIT];
		tick     = (s_r.qtr == `PMT8_QTR_TC);
		inc      = 1'b0;
		set_flag = 1'b0;
		clr_flag = 1'b0;
		s_nxt.ack   = acc;
		s_nxt.match = 1'b0;

		// instruction clock divider
		s_nxt.qtr = s_r.qtr + 2'h1;

		// prescaler terminal count
		case (s_r.ctl[`PMT8_PS_MSB:`PMT8_PS_LSB])
			`PMT8_PS_DIV1: pre_tc = `PMT8_PRE_TC1;
			`PMT8_PS_DIV4: pre_tc = `PMT8_PRE_TC4;
			default:       pre_tc = `PMT8_PRE_TC16;
		endcase

		// counters hold while off
		if (run && tick) begin
			if (s_r.pre == pre_tc) begin
				s_nxt.pre = 4'h0;
				inc       = 1'b1;
			end else begin
				s_nxt.pre = s_r.pre + 4'h1;
			end
		end

		if (inc) begin
			if (s_r.cnt == s_r.per) begin
				s_nxt.cnt   = `PMT8_COUNT_RST;
				s_nxt.match = 1'b1;
				s_nxt.shclk = ~s_r.shclk;
				if (s_r.post == s_r.ctl[`PMT8_POST_MSB:`PMT8_POST_LSB]) begin
					s_nxt.post = 4'h0;
					set_flag   = 1'b1;
				end else begin
					s_nxt.post = s_r.post + 4'h1;
				end
			end else begin
				s_nxt.cnt = s_r.cnt + 8'h01;
			end
		end

		// register reads
		if (acc) begin
			case (idx)
				`PMT8_IDX_COUNT:   s_nxt.dat = {`PMT8_HI_ZERO, s_r.cnt};
				`PMT8_IDX_PERIOD:  s_nxt.dat = {`PMT8_HI_ZERO, s_r.per};
				`PMT8_IDX_CONTROL: s_nxt.dat = {`PMT8_HI_ZERO, 1'b0, s_r.ctl};
				`PMT8_IDX_FLAG:    s_nxt.dat = {`PMT8_FLAG_HI_ZERO, s_r.flag, `PMT8_BIT0_ZERO};
				`PMT8_IDX_ENABLE:  s_nxt.dat = {`PMT8_FLAG_HI_ZERO, s_r.ien, `PMT8_BIT0_ZERO};
				default:           s_nxt.dat = `PMT8_DATA_ZERO;
			endcase
		end

		// register writes override the counting above
		if (wr) begin
			case (idx)
				`PMT8_IDX_COUNT: begin
					s_nxt.cnt  = wbyte;
					s_nxt.pre  = 4'h0;
					s_nxt.post = 4'h0;
				end
				`PMT8_IDX_PERIOD: begin
					s_nxt.per = wbyte;
				end
				`PMT8_IDX_CONTROL: begin
					s_nxt.ctl  = wbyte[6:0];
					s_nxt.pre  = 4'h0;
					s_nxt.post = 4'h0;
				end
				`PMT8_IDX_FLAG: begin
					clr_flag = wbyte[`PMT8_IRQ_BIT];
				end
				`PMT8_IDX_ENABLE: begin
					s_nxt.ien = wbyte[`PMT8_IRQ_BIT];
				end
				default: begin
					s_nxt.ien = s_r.ien;
				end
			endcase
		end

		// set wins over a same-cycle clear
		s_nxt.flag = (s_r.flag & ~clr_flag) | set_flag;
	end

	// ==========================================================
	// state register
	always_ff @(posedge mclk or negedge rst_l) begin
		if (!rst_l) begin
			s_r <= ST_RST;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// outputs
	assign wb_dat_o    = s_r.dat;
	assign wb_ack_o    = s_r.ack;
	assign irq         = s_r.flag & s_r.ien;
	assign match_pulse = s_r.match;
	assign shift_clk   = s_r.shclk;

endmodule : pmt8_top
`default_nettype wire

// [test/pmt8_chk.sv]
// Purpose: port assertions of pmt8_top
// Assumes: ce held high by the bench
// Notes:   bound into pmt8_top below
`timescale 1ns/1ps
`default_nettype none
module pmt8_chk (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        ce,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        irq,
	input wire logic        match_pulse,
	input wire logic        shift_clk
);
	logic req;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_ack_taken: assert property (req |=> wb_ack_o) else $error("ack missing");
	a_ack_cause: assert property (wb_ack_o |-> $past(req)) else $error("stray ack");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	a_ctl_bit7: assert property (wb_ack_o && !wb_we_i && wb_adr_i[4:2] == 3'h2 |-> !wb_dat_o[7])
		else $error("control bit 7 set");
	a_match_gap: assert property (match_pulse |=> !match_pulse [*3]) else $error("match too soon");
	a_shift_follows: assert property ($changed(shift_clk) == match_pulse) else $error("shift clock");
	a_irq_masked: assert property (req && wb_we_i && wb_sel_i[0] && wb_adr_i[4:2] == 3'h4 && !wb_dat_i[1]
		|=> !irq) else $error("masked irq high");
endmodule : pmt8_chk

bind pmt8_top pmt8_chk chk_u (.mclk(mclk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
	.match_pulse(match_pulse), .shift_clk(shift_clk));
`default_nettype wire

// [test/test_period_match_timer8.sv]
// Purpose: register level test of pmt8_top
// Assumes: 25 MHz mclk, classic Wishbone single cycles
// Notes:   ce and sel tied on
`timescale 1ns/1ps
`default_nettype none
module test_period_match_timer8;
	logic        mclk, rst_n, cyc, stb, we, ack, irq, mp;
	logic [31:0] adr, wdat, q, rdat;
	int          mismatches, comparisons, ps, k, c, m, n;

	pmt8_top dut_u (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(q),
		.wb_ack_o(ack), .irq(irq), .match_pulse(mp), .shift_clk());

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task end_sim();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk

	task bus(input logic w, input logic [2:0] i, input logic [7:0] d);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {27'h000_0000, i, 2'h0};
		wdat <= {24'h00_0000, d};
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rdat = q;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			mismatches++;
			$display("unexpected at %0t: no ack", $time);
			end_sim();
		end
	endtask : bus

	task rd(input logic [2:0] i, input logic [7:0] e);
		bus(1'b0, i, 8'h00);
		chk(rdat, {24'h00_0000, e});
	endtask : rd

	// waits for a match, then counts cycles to the next one
	task gap();
		n = 0;
		do @(posedge mclk); while (mp !== 1'b1 && ++n < 400);
		c = 0;
		do @(posedge mclk); while (mp !== 1'b1 && ++c < 400);
		if (n >= 400 || c >= 400) begin
			mismatches++;
			$display("unexpected at %0t: no match", $time);
			end_sim();
		end
	endtask : gap

	initial begin
		{rst_n, cyc, stb, we, adr, wdat, mismatches, comparisons} = '0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (2) @(posedge mclk);
		rd(3'h0, 8'h00);
		rd(3'h1, 8'hFF);
		rd(3'h2, 8'h00);
		bus(1'b1, 3'h2, 8'hFB);
		rd(3'h2, 8'h7B);
		bus(1'b1, 3'h0, 8'h03);
		repeat (40) @(posedge mclk);
		rd(3'h0, 8'h03);
		bus(1'b1, 3'h2, 8'h06);
		rd(3'h0, 8'h03);
		bus(1'b1, 3'h1, 8'h02);
		rd(3'h1, 8'h02);
		bus(1'b1, 3'h0, 8'h00);
		for (ps = 0; ps < 4; ps++) begin
			bus(1'b1, 3'h2, 8'h04 | 8'(ps));
			gap();
			gap();
			chk(c + 1, 12 * ((ps == 0) ? 1 : (ps == 1) ? 4 : 16));
		end
		bus(1'b1, 3'h1, 8'h01);
		for (k = 0; k < 16; k += 5) begin
			bus(1'b1, 3'h2, 8'h00);
			bus(1'b1, 3'h3, 8'h02);
			bus(1'b1, 3'h4, 8'h02);
			bus(1'b1, 3'h0, 8'h00);
			bus(1'b1, 3'h2, {1'b0, 4'(k), 3'h4});
			m = 0;
			n = 0;
			do begin
				@(posedge mclk);
				m += (mp === 1'b1);
			end while (irq !== 1'b1 && ++n < 400);
			chk(m, k + 1);
			chk(irq, 1'b1);
		end
		bus(1'b1, 3'h4, 8'h00);
		chk(irq, 1'b0);
		bus(1'b1, 3'h4, 8'h02);
		chk(irq, 1'b1);
		bus(1'b1, 3'h2, 8'h00);
		bus(1'b1, 3'h3, 8'h02);
		chk(irq, 1'b0);
		end_sim();
	end
endmodule : test_period_match_timer8
`default_nettype wire
